// ### core/mpc_pkg.sv
// shared constants and carriers of the monitor pin control block
// assumes a 20 MHz apb clock and pad decoders outside the core
package mpc_pkg;
  // -----------------------------------------------------------
  // timing
  // -----------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int CI_CLR_MS = 20;
  localparam int RST_PULSE_MS = 45;
  localparam int CI_CLR_CYC = (CI_CLR_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 20;
  localparam logic [2:0] BLANK_CYC = 3'h7;
  // -----------------------------------------------------------
  // register map
  // -----------------------------------------------------------
  localparam logic [11:0] CFG_IDX = 12'h040;
  localparam logic [11:0] CLR_IDX = 12'h046;
  localparam logic [11:0] ADDR_CFG = CFG_IDX << 2;
  localparam logic [11:0] ADDR_CLR = CLR_IDX << 2;
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_ISTAT = 12'h008;
  localparam logic [11:0] ADDR_IMASK = 12'h00C;
  localparam int CFG_IRQ_EN = 1;
  localparam int CFG_RST_PULSE = 4;
  localparam int CFG_CI_CLR = 6;
  localparam int CLR_CI_CLR = 7;
  // -----------------------------------------------------------
  // events and pins
  // -----------------------------------------------------------
  localparam int EV_W = 4;
  localparam int EV_CI = 0;
  localparam int EV_THERMAL_INTERRUPT_PIN = 1;
  localparam int EV_CLR_DONE = 2;
  localparam int EV_RST_DONE = 3;
  localparam int PIN_W = 8;
  localparam int PIN_ADDR0 = 0;
  localparam int PIN_THERMAL_INTERRUPT_PIN = 2;
  localparam int PIN_CI = 3;
  localparam int PIN_TACH1 = 4;
  localparam int PIN_TACH2 = 5;
  localparam int PIN_TEST = 6;
  localparam int PIN_RST = 7;
  localparam logic [7:0] SYNC_RST = 8'h84;
  localparam logic [1:0] ADDR_LVL_BAD = 2'h3;
  localparam logic [1:0] ADDR_LSB_RST = 2'h0;
  localparam logic [EV_W-1:0] EV_ZERO = 4'h0;
  // -----------------------------------------------------------
  // carriers
  // -----------------------------------------------------------
  typedef struct packed {
    logic second_core_voltage_input_diode;
    logic tach_input_two_tach;
    logic tach_input_one_tach;
    logic thermal_in_role;
  } mpc_mode_t;
  localparam mpc_mode_t MODE_RST = 4'h0;
  typedef struct packed {
    logic programmable_analog_out_en;
    logic diode_two_en;
    logic second_core_voltage_input_mon_en;
    logic tach_two_en;
    logic aux_two_en;
    logic tach_one_en;
    logic aux_one_en;
  } mpc_pad_sel_t;
  localparam mpc_pad_sel_t PAD_SEL_RST = 7'h55;
  typedef struct packed {
    logic rst_busy;
    logic ci_busy;
    logic ci_level;
    logic thermal_level;
    logic test_mode;
    logic [1:0] addr_lsb;
  } mpc_status_t;
endpackage

// ### core/mpc_pin_ctrl.sv
// pin function control of a hardware monitor, apb register slave
// assumes pads split two-way pins into in/out/oe and a three-level
// decoder that reports the address pin as 00 low, 01 open, 10 high
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mpc_pin_ctrl #(
  parameter int unsigned CI_CLR_CYCLES = mpc_pkg::CI_CLR_CYC,
  parameter int unsigned RST_CYCLES = mpc_pkg::RST_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [1:0] addr_level,
  output logic test_result_output,
  output logic test_result_oe,
  output logic [1:0] slave_addr_lsb,
  input wire logic thermal_interrupt_pin,
  output logic thermal_out,
  output logic thermal_oe,
  input wire logic temp_alert,
  output logic fan_full_speed,
  input wire logic intrusion_sense_pin,
  output logic intrusion_out,
  output logic intrusion_oe,
  input wire logic tach_input_one,
  input wire logic tach_input_two,
  input wire logic test_mode_input,
  output logic test_mode,
  output logic int_req_out,
  output logic int_req_oe,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output mpc_pkg::mpc_pad_sel_t pad_sel
);
  import mpc_pkg::*;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] sy;
  logic od_zero;
  logic srst;
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] rdata;
  mpc_mode_t mode;
  mpc_status_t status;
  logic irq_en;
  logic [EV_W-1:0] int_stat;
  logic [EV_W-1:0] int_mask;
  logic [EV_W-1:0] ev;
  logic ci_start;
  logic rst_start;
  logic [CNT_W-1:0] ci_cnt;
  logic [CNT_W-1:0] rst_cnt;
  logic [2:0] ci_blank;
  logic [2:0] rst_blank;
  logic ci_hi;
  logic ci_hi_q;
  logic thermal_interrupt_pin_q;
  logic nand_out;

  // -----------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------
  assign pin_raw = {reset_pin_in, test_mode_input, tach_input_two,
                    tach_input_one, intrusion_sense_pin,
                    thermal_interrupt_pin, addr_level};

  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1[i] <= SYNC_RST[i];
        sync2[i] <= SYNC_RST[i];
        sync3[i] <= SYNC_RST[i];
        sy[i] <= SYNC_RST[i];
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          sy[i] <= sync3[i];
        end
      end
    end
  end

  // outside pull of the reset pin, own pulse and its tail masked
  assign srst = !sy[PIN_RST] && !reset_pin_oe && rst_blank == 3'h0;

  // -----------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign ci_start = wr && ((paddr == ADDR_CFG && pwdata[CFG_CI_CLR]) ||
                    (paddr == ADDR_CLR && pwdata[CLR_CI_CLR]));
  assign rst_start = wr && paddr == ADDR_CFG && pwdata[CFG_RST_PULSE];
  assign status = '{rst_busy: reset_pin_oe, ci_busy: intrusion_oe,
                    ci_level: sy[PIN_CI], thermal_level: sy[PIN_THERMAL_INTERRUPT_PIN],
                    test_mode: test_mode, addr_lsb: slave_addr_lsb};

  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      ADDR_MODE: rdata[3:0] = mode;
      ADDR_STATUS: rdata[6:0] = status;
      ADDR_ISTAT: rdata[EV_W-1:0] = int_stat;
      ADDR_IMASK: rdata[EV_W-1:0] = int_mask;
      ADDR_CFG: begin
        rdata[CFG_IRQ_EN] = irq_en;
        rdata[CFG_RST_PULSE] = reset_pin_oe;
        rdata[CFG_CI_CLR] = intrusion_oe;
      end
      ADDR_CLR: rdata[CLR_CI_CLR] = intrusion_oe;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
      pslverr <= psel && !penable && !hit;
    end
  end

  // -----------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RST;
      irq_en <= 1'b0;
      int_mask <= EV_ZERO;
    end else if (srst) begin
      mode <= MODE_RST;
      irq_en <= 1'b0;
      int_mask <= EV_ZERO;
    end else if (wr) begin
      if (paddr == ADDR_MODE) begin
        mode <= mpc_mode_t'(pwdata[3:0]);
      end
      if (paddr == ADDR_CFG) begin
        irq_en <= pwdata[CFG_IRQ_EN];
      end
      if (paddr == ADDR_IMASK) begin
        int_mask <= pwdata[EV_W-1:0];
      end
    end
  end

  // -----------------------------------------------------------
  // pin roles
  // -----------------------------------------------------------
  always_comb begin
    nand_out = 1'b1;
    for (int k = PIN_THERMAL_INTERRUPT_PIN; k <= PIN_TACH2; k++) begin
      nand_out = !(nand_out && sy[k]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_zero <= 1'b0;
      test_mode <= 1'b0;
      test_result_oe <= 1'b0;
      test_result_output <= 1'b0;
      slave_addr_lsb <= ADDR_LSB_RST;
      pad_sel <= PAD_SEL_RST;
      thermal_oe <= 1'b0;
      fan_full_speed <= 1'b0;
    end else begin
      od_zero <= 1'b0;
      test_mode <= sy[PIN_TEST];
      test_result_oe <= sy[PIN_TEST];
      test_result_output <= nand_out;
      if (!sy[PIN_TEST] && sy[1:0] != ADDR_LVL_BAD) begin
        slave_addr_lsb <= sy[1:0];
      end
      pad_sel.programmable_analog_out_en <= !sy[PIN_TEST];
      pad_sel.aux_one_en <= !mode.tach_input_one_tach;
      pad_sel.tach_one_en <= mode.tach_input_one_tach;
      pad_sel.aux_two_en <= !mode.tach_input_two_tach;
      pad_sel.tach_two_en <= mode.tach_input_two_tach;
      pad_sel.second_core_voltage_input_mon_en <= !mode.second_core_voltage_input_diode;
      pad_sel.diode_two_en <= mode.second_core_voltage_input_diode;
      thermal_oe <= !mode.thermal_in_role && temp_alert;
      fan_full_speed <= mode.thermal_in_role && !sy[PIN_THERMAL_INTERRUPT_PIN];
    end
  end

  assign thermal_out = od_zero;
  assign intrusion_out = od_zero;
  assign int_req_out = od_zero;
  assign reset_pin_out = od_zero;

  // -----------------------------------------------------------
  // timed open-drain pulses
  // -----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_cnt <= '0;
      intrusion_oe <= 1'b0;
      ci_blank <= 3'h0;
    end else if (srst) begin
      ci_cnt <= '0;
      intrusion_oe <= 1'b0;
      ci_blank <= 3'h0;
    end else begin
      if (ci_start) begin
        ci_cnt <= CNT_W'(CI_CLR_CYCLES);
      end else if (ci_cnt != '0) begin
        ci_cnt <= ci_cnt - CNT_W'(1);
      end
      intrusion_oe <= ci_start || ci_cnt > CNT_W'(1);
      if (intrusion_oe) begin
        ci_blank <= BLANK_CYC;
      end else if (ci_blank != 3'h0) begin
        ci_blank <= ci_blank - 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= '0;
      reset_pin_oe <= 1'b0;
      rst_blank <= 3'h0;
    end else begin
      if (rst_start) begin
        rst_cnt <= CNT_W'(RST_CYCLES);
      end else if (rst_cnt != '0) begin
        rst_cnt <= rst_cnt - CNT_W'(1);
      end
      reset_pin_oe <= rst_start || rst_cnt > CNT_W'(1);
      if (reset_pin_oe) begin
        rst_blank <= BLANK_CYC;
      end else if (rst_blank != 3'h0) begin
        rst_blank <= rst_blank - 3'h1;
      end
    end
  end

  // -----------------------------------------------------------
  // events and interrupt
  // -----------------------------------------------------------
  assign ci_hi = sy[PIN_CI] && !intrusion_oe && ci_blank == 3'h0;
  always_comb begin
    ev = EV_ZERO;
    ev[EV_CI] = ci_hi && !ci_hi_q;
    ev[EV_THERMAL_INTERRUPT_PIN] = mode.thermal_in_role && thermal_interrupt_pin_q && !sy[PIN_THERMAL_INTERRUPT_PIN];
    ev[EV_CLR_DONE] = ci_cnt == CNT_W'(1) && !ci_start;
    ev[EV_RST_DONE] = rst_cnt == CNT_W'(1) && !rst_start;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= EV_ZERO;
      ci_hi_q <= 1'b0;
      thermal_interrupt_pin_q <= 1'b1;
      irq <= 1'b0;
      int_req_oe <= 1'b0;
    end else if (srst) begin
      int_stat <= EV_ZERO;
      ci_hi_q <= 1'b0;
      thermal_interrupt_pin_q <= 1'b1;
      irq <= 1'b0;
      int_req_oe <= 1'b0;
    end else begin
      ci_hi_q <= ci_hi;
      thermal_interrupt_pin_q <= sy[PIN_THERMAL_INTERRUPT_PIN];
      if (rd && paddr == ADDR_ISTAT) begin
        int_stat <= (int_stat & ~prdata[EV_W-1:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
      irq <= |(int_stat & int_mask);
      int_req_oe <= irq_en && |(int_stat & int_mask);
    end
  end

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [CNT_W-1:0] ci_len, rst_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_len <= '0;
      rst_len <= '0;
    end else begin
      ci_len <= (intrusion_oe && !ci_start) ? ci_len + CNT_W'(1) : '0;
      rst_len <= (reset_pin_oe && !rst_start) ? rst_len + CNT_W'(1) : '0;
    end
  end

  a_addr_lsb_follow: assert property (
    !sy[PIN_TEST] && sy[1:0] != ADDR_LVL_BAD |=> slave_addr_lsb == $past(sy[1:0]))
    else $error("slave address bits do not follow the pin");
  a_test_drive_out: assert property (
    sy[PIN_TEST] |=> test_result_oe && test_mode)
    else $error("address pin not driven in nand test");
  a_thermal_interrupt_pin_input_role: assert property (
    mode.thermal_in_role |=> !thermal_oe)
    else $error("thermal pin driven while an input");
  a_ci_sets_flag: assert property (
    ci_hi && !ci_hi_q && !srst |=> int_stat[EV_CI])
    else $error("intrusion level not flagged");
  a_ci_pulse_len: assert property (
    $fell(intrusion_oe) && !$past(srst) |-> ci_len == CNT_W'(CI_CLR_CYCLES))
    else $error("intrusion clear pulse has wrong length");
  a_int_pin_enable: assert property (
    !irq_en |=> !int_req_oe)
    else $error("interrupt pin driven while disabled");
  a_rst_pulse_len: assert property (
    $fell(reset_pin_oe) |-> rst_len == CNT_W'(RST_CYCLES))
    else $error("reset pulse has wrong length");
  a_ext_reset_defaults: assert property (
    srst |=> mode == MODE_RST && !irq_en && int_stat == EV_ZERO)
    else $error("reset pin did not restore defaults");
  a_programmable_analog_out_select: assert property (
    !sy[PIN_TEST] |=> pad_sel.programmable_analog_out_en)
    else $error("analog output not selected outside test");
  a_pad_roles: assert property (
    ##1 pad_sel.tach_one_en == $past(mode.tach_input_one_tach) &&
    pad_sel.diode_two_en == $past(mode.second_core_voltage_input_diode))
    else $error("pad role does not match mode");
  a_ci_release: assert property (
    ci_cnt == CNT_W'(1) && !ci_start && !srst |=> !intrusion_oe [*2])
    else $error("intrusion open drain not released");

  c_ci_clear: cover property ($fell(intrusion_oe));
  c_rst_pulse: cover property ($fell(reset_pin_oe));
  c_nand_test: cover property ($rose(test_result_oe));
  c_int_pin: cover property ($rose(int_req_oe));
endmodule
`default_nettype wire

// ### tb/mpc_board_model.sv
// board-side model: intrusion latch, pulled-up thermal and reset pins
// assumes the bench gives latch events, thermal pulls and board resets
`timescale 1ns/1ns
`default_nettype none
module mpc_board_model (
  input wire logic pclk,
  input wire logic intrude,
  input wire logic thermal_interrupt_pin_pull,
  input wire logic ext_rst_n,
  input wire logic intrusion_oe,
  input wire logic thermal_oe,
  input wire logic reset_pin_oe,
  output logic intrusion_sense_pin,
  output logic thermal_interrupt_pin,
  output logic reset_pin_in
);
  // -----------------------------------------------------------
  // intrusion latch
  // -----------------------------------------------------------
  logic latched = 1'b0;
  always @(posedge pclk) begin
    if (intrusion_oe) begin
      latched <= 1'b0;
    end else if (intrude) begin
      latched <= 1'b1;
    end
  end
  assign intrusion_sense_pin = latched & ~intrusion_oe;
  // -----------------------------------------------------------
  // wired pins with pull-ups
  // -----------------------------------------------------------
  assign thermal_interrupt_pin = ~(thermal_oe | thermal_interrupt_pin_pull);
  assign reset_pin_in = ext_rst_n & ~reset_pin_oe;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench of the monitor pin control block
// assumes short pulse counts of 20 and 40 cycles and the board model
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mpc_pkg::*;
  localparam int CIN = 20;
  localparam int RSN = 40;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serr, irq, tro, tro_oe, th_in, th_out, th_oe;
  logic [1:0] addr_level = 2'h0, lsb;
  logic temp_alert = 0, ffs, ci_pin, ci_out, ci_oe, tach1 = 1, tach2 = 1;
  logic test_in = 0, test_mode, irq_out, irq_oe, rst_in, rst_out, rst_oe;
  logic intrude = 0, thermal_interrupt_pin_pull = 0, ext_rst_n = 1;
  mpc_pad_sel_t pad_sel;
  int err_count = 0, n_checks = 0, cyc = 0, n;
  always #25 pclk = ~pclk;
  mpc_pin_ctrl #(.CI_CLR_CYCLES(CIN), .RST_CYCLES(RSN)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .addr_level(addr_level), .test_result_output(tro),
    .test_result_oe(tro_oe), .slave_addr_lsb(lsb),
    .thermal_interrupt_pin(th_in), .thermal_out(th_out),
    .thermal_oe(th_oe), .temp_alert(temp_alert), .fan_full_speed(ffs),
    .intrusion_sense_pin(ci_pin), .intrusion_out(ci_out),
    .intrusion_oe(ci_oe), .tach_input_one(tach1),
    .tach_input_two(tach2), .test_mode_input(test_in),
    .test_mode(test_mode), .int_req_out(irq_out), .int_req_oe(irq_oe),
    .reset_pin_in(rst_in), .reset_pin_out(rst_out),
    .reset_pin_oe(rst_oe), .pad_sel(pad_sel));
  mpc_board_model board (
    .pclk(pclk), .intrude(intrude), .thermal_interrupt_pin_pull(thermal_interrupt_pin_pull),
    .ext_rst_n(ext_rst_n), .intrusion_oe(ci_oe), .thermal_oe(th_oe),
    .reset_pin_oe(rst_oe), .intrusion_sense_pin(ci_pin),
    .thermal_interrupt_pin(th_in), .reset_pin_in(rst_in));
  // -----------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // entered just after a rising edge; leaves one edge after release
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // first pulse cycle passes inside the write task
  task automatic pulse_len(input logic sel, output int cnt);
    cnt = 0;
    repeat (2000) begin
      @(posedge pclk);
      if ((sel ? rst_oe : ci_oe) === 1'b1) cnt++;
      else if (cnt > 0) break;
    end
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_reset();
    apb(0, ADDR_MODE, 0);
    chk(rd, 32'h0);
    apb(0, ADDR_CFG, 0);
    chk(rd & 32'h2, 32'h0);
    chk({31'h0, irq_oe}, 32'h0);
    chk({25'h0, pad_sel}, {25'h0, PAD_SEL_RST});
    apb(0, 12'h010, 0);
    chk({31'h0, serr}, 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_addr();
    for (int i = 0; i < 3; i++) begin
      addr_level <= i[1:0];
      repeat (8) @(posedge pclk);
      chk({30'h0, lsb}, i);
      apb(0, ADDR_STATUS, 0);
      chk(rd & 32'h3, i);
    end
    addr_level <= ADDR_LVL_BAD;
    repeat (8) @(posedge pclk);
    chk({30'h0, lsb}, 32'h2);
  endtask
  task automatic t_test();
    test_in <= 1;
    repeat (8) @(posedge pclk);
    chk({31'h0, test_mode}, 32'h1);
    chk({31'h0, tro_oe}, 32'h1);
    chk({31'h0, pad_sel.programmable_analog_out_en}, 32'h0);
    chk({31'h0, tro}, 32'h1);
    tach1 <= 0;
    repeat (8) @(posedge pclk);
    chk({31'h0, tro}, 32'h0);
    tach1 <= 1;
    test_in <= 0;
    repeat (8) @(posedge pclk);
    chk({31'h0, tro_oe}, 32'h0);
    chk({31'h0, pad_sel.programmable_analog_out_en}, 32'h1);
  endtask
  task automatic t_thermal_interrupt_pin();
    temp_alert <= 1;
    repeat (3) @(posedge pclk);
    chk({31'h0, th_oe}, 32'h1);
    apb(1, ADDR_MODE, 32'h1);
    apb(0, ADDR_ISTAT, 0);
    thermal_interrupt_pin_pull <= 1;
    repeat (8) @(posedge pclk);
    chk({30'h0, th_oe, ffs}, 32'h1);
    apb(0, ADDR_ISTAT, 0);
    chk(rd & 32'h2, 32'h2);
    thermal_interrupt_pin_pull <= 0;
    temp_alert <= 0;
  endtask
  task automatic t_intr();
    apb(1, ADDR_IMASK, 32'h1);
    apb(1, ADDR_CFG, 32'h2);
    apb(0, ADDR_ISTAT, 0);
    intrude <= 1;
    @(posedge pclk);
    intrude <= 0;
    repeat (8) @(posedge pclk);
    chk({30'h0, irq, irq_oe}, 32'h3);
    chk({28'h0, th_out, ci_out, irq_out, rst_out}, 32'h0);
    apb(1, ADDR_CFG, 32'h0);
    repeat (2) @(posedge pclk);
    chk({30'h0, irq, irq_oe}, 32'h2);
    apb(0, ADDR_ISTAT, 0);
    chk(rd & 32'h1, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1, ADDR_CFG, 32'h40);
    pulse_len(0, n);
    chk(n, CIN - 1);
    chk({31'h0, ci_pin}, 32'h0);
    apb(0, ADDR_ISTAT, 0);
    chk(rd & 32'h5, 32'h4);
    intrude <= 1;
    @(posedge pclk);
    intrude <= 0;
    repeat (10) @(posedge pclk);
    apb(1, ADDR_CLR, 32'h80);
    pulse_len(0, n);
    chk(n, CIN - 1);
    chk({31'h0, ci_pin}, 32'h0);
  endtask
  task automatic t_rstpulse();
    apb(1, ADDR_CFG, 32'h10);
    pulse_len(1, n);
    chk(n, RSN - 1);
    repeat (12) @(posedge pclk);
    chk({31'h0, rst_oe}, 32'h0);
  endtask
  task automatic t_modes();
    apb(1, ADDR_MODE, 32'hE);
    repeat (2) @(posedge pclk);
    chk({27'h0, pad_sel.diode_two_en, pad_sel.tach_two_en,
         pad_sel.aux_two_en, pad_sel.tach_one_en, pad_sel.aux_one_en},
        32'h1A);
    chk({31'h0, pad_sel.second_core_voltage_input_mon_en}, 32'h0);
  endtask
  task automatic t_extrst();
    apb(1, ADDR_IMASK, 32'hF);
    ext_rst_n <= 0;
    repeat (10) @(posedge pclk);
    ext_rst_n <= 1;
    repeat (12) @(posedge pclk);
    apb(0, ADDR_MODE, 0);
    chk(rd, 32'h0);
    apb(0, ADDR_IMASK, 0);
    chk(rd, 32'h0);
    chk({25'h0, pad_sel}, {25'h0, PAD_SEL_RST});
  endtask
  // -----------------------------------------------------------
  // main sequence and hang guard
  // -----------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_addr();
    t_test();
    t_thermal_interrupt_pin();
    t_intr();
    t_rstpulse();
    t_modes();
    t_extrst();
    print_verdict();
  end
endmodule
`default_nettype wire
